// *** logic/atg_defines.svh ***
`ifndef ATG_DEFINES_SVH
`define ATG_DEFINES_SVH

// 25 MHz acquisition clock, 40 ns period
`define ATG_CLK_HZ        32'h017D_7840
`define ATG_CLK_PERIOD_NS 8'h28
// cycles per microsecond: 1000 ns / 40 ns
`define ATG_CYC_PER_US    (16'h03E8 / `ATG_CLK_PERIOD_NS)

`define ATG_CNT_W         32
`define ATG_EXP_W         24
`define ATG_AOI_W         12
`define ATG_RDC_W         16
`define ATG_FPS_W         16

`define ATG_NUM_LINES     4
`define ATG_LINE_W        2
// output line 2 sits at index 1
`define ATG_DEF_LINE      2'h1

`define ATG_MIN_EXP       32'h0000_0001
`define ATG_CNT_MAX       32'hFFFF_FFFF

`endif

// *** logic/atg_pkg.sv ***
package atg_pkg;

  typedef enum logic {
    ATG_SRC_OFF,
    ATG_SRC_SAFE
  } atg_src_t;

  typedef enum logic {
    ATG_DIV_IDLE,
    ATG_DIV_RUN
  } atg_div_st_t;

endpackage

// *** logic/atg_rate_div.sv ***
`timescale 1ns/1ps
`include "atg_defines.svh"

// serial divider: clock rate over acquisitions per second
module atg_rate_div
  import atg_pkg::*;
(
  input  wire logic                  i_clk,      // acquisition clock
  input  wire logic                  i_resetn,   // sync reset, low
  input  wire logic                  i_start,    // begin division
  input  wire logic [`ATG_FPS_W-1:0] i_fps,      // divisor, nonzero
  output logic                       o_busy,     // division running
  output logic                       o_done,     // result ready pulse
  output logic [`ATG_CNT_W-1:0]      o_period    // cycles per frame
);

  atg_div_st_t             st_reg,   st_next;
  logic [`ATG_CNT_W-1:0]   dvd_reg,  dvd_next;
  logic [`ATG_CNT_W-1:0]   quo_reg,  quo_next;
  logic [`ATG_FPS_W:0]     rem_reg,  rem_next;
  logic [`ATG_FPS_W-1:0]   dsr_reg,  dsr_next;
  logic [5:0]              bit_reg,  bit_next;
  logic                    done_reg, done_next;
  logic [`ATG_FPS_W:0]     rem_sh;

  always_comb begin
    st_next   = st_reg;
    dvd_next  = dvd_reg;
    quo_next  = quo_reg;
    rem_next  = rem_reg;
    dsr_next  = dsr_reg;
    bit_next  = bit_reg;
    done_next = 1'b0;
    rem_sh    = {rem_reg[`ATG_FPS_W-1:0], dvd_reg[`ATG_CNT_W-1]};
    unique case (st_reg)
      ATG_DIV_IDLE: begin
        if (i_start) begin
          st_next  = ATG_DIV_RUN;
          dvd_next = `ATG_CLK_HZ;
          rem_next = '0;
          dsr_next = i_fps;
          bit_next = 6'h20;
        end
      end
      ATG_DIV_RUN: begin
        dvd_next = {dvd_reg[`ATG_CNT_W-2:0], 1'b0};
        if (rem_sh >= {1'b0, dsr_reg}) begin
          rem_next = rem_sh - {1'b0, dsr_reg};
          quo_next = {quo_reg[`ATG_CNT_W-2:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          quo_next = {quo_reg[`ATG_CNT_W-2:0], 1'b0};
        end
        bit_next = bit_reg - 6'h01;
        if (bit_reg == 6'h01) begin
          st_next   = ATG_DIV_IDLE;
          done_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_reg   <= ATG_DIV_IDLE;
      dvd_reg  <= '0;
      quo_reg  <= '0;
      rem_reg  <= '0;
      dsr_reg  <= '0;
      bit_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      dvd_reg  <= dvd_next;
      quo_reg  <= quo_next;
      rem_reg  <= rem_next;
      dsr_reg  <= dsr_next;
      bit_reg  <= bit_next;
      done_reg <= done_next;
    end
  end

  assign o_busy   = (st_reg == ATG_DIV_RUN);
  assign o_done   = done_reg;
  assign o_period = quo_reg;

endmodule

// *** logic/atg_line_router.sv ***
`timescale 1ns/1ps
`include "atg_defines.svh"

// per-line source selection for the physical output lines
module atg_line_router
  import atg_pkg::*;
(
  input  wire logic                     i_clk,        // acquisition clock
  input  wire logic                     i_resetn,     // sync reset, low
  input  wire logic                     i_safe,       // indicator level
  input  wire logic [`ATG_LINE_W-1:0]   i_sel,        // chosen line
  input  wire logic                     i_src_safe,   // 1: safe, 0: off
  input  wire logic                     i_wr,         // source write
  output logic [`ATG_NUM_LINES-1:0]     o_line        // line levels
);

  genvar k;
  generate
    for (k = 0; k < `ATG_NUM_LINES; k++) begin : g_line
      atg_src_t src_reg, src_next;
      logic     out_reg, out_next;

      always_comb begin
        src_next = src_reg;
        if (i_wr && (i_sel == `ATG_LINE_W'(k))) begin
          src_next = i_src_safe ? ATG_SRC_SAFE : ATG_SRC_OFF;
        end
        out_next = (src_reg == ATG_SRC_SAFE) && i_safe;
      end

      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          src_reg <= (k == `ATG_DEF_LINE) ? ATG_SRC_SAFE : ATG_SRC_OFF;
          out_reg <= 1'b0;
        end else begin
          src_reg <= src_next;
          out_reg <= out_next;
        end
      end

      assign o_line[k] = out_reg;
    end
  endgenerate

endmodule

// *** logic/atg_gate.sv ***
`timescale 1ns/1ps
`include "atg_defines.svh"

// Overview of operation
// - overlapped: no exposure start during exposure
// - overlapped: exposure ends after prior readout
// - non-overlap: exposure starts after readout ends
// - standard mode: indicator follows frame start
// - legacy mode: indicator follows acquisition start
// - rise when safe, fall on acquisition start
// - rise from exposure, AOI, readout time
// - enabled rate limit paces indicator rise
// - limit above maximum is ignored
// - triggers while indicator low are discarded
// - indicator only with hardware triggering
// - reset routes indicator to line 2
// - choose line, then set its source
module atg_gate
  import atg_pkg::*;
(
  input  wire logic                  i_clk,           // 25 MHz clock
  input  wire logic                  i_resetn,        // sync reset, low
  input  wire logic                  i_trig_frame,    // frame start pin
  input  wire logic                  i_trig_acq,      // acq start pin
  input  wire logic                  i_legacy_mode,   // 1: legacy mode
  input  wire logic                  i_hw_trig_en,    // hw trigger on
  input  wire logic                  i_overlap_en,    // overlap variant
  input  wire logic [`ATG_EXP_W-1:0] i_exposure_us,   // exposure, us
  input  wire logic [`ATG_AOI_W-1:0] i_aoi_height,    // AOI rows
  input  wire logic [`ATG_RDC_W-1:0] i_rd_line_cyc,   // cycles per row
  input  wire logic [`ATG_RDC_W-1:0] i_rd_fixed_cyc,  // fixed readout
  input  wire logic                  i_rate_lim_en,   // rate limit on
  input  wire logic [`ATG_FPS_W-1:0] i_rate_fps,      // limit, per s
  input  wire logic [`ATG_LINE_W-1:0] i_choose_output_line, // line
  input  wire logic                  i_source_is_safe_indicator, // src
  input  wire logic                  i_line_src_wr,   // source write
  output logic                       o_safe_to_trigger_indicator, // rdy
  output logic                       o_acq_start,     // accepted pulse
  output logic                       o_trig_discard,  // ignored pulse
  output logic                       o_exposing,      // exposure on
  output logic                       o_reading,       // readout on
  output logic [`ATG_NUM_LINES-1:0]  o_line           // output lines
);

  // pin synchronisers and edge detect
  logic [2:0] frm_sync_reg, frm_sync_next;
  logic [2:0] acq_sync_reg, acq_sync_next;
  logic       frm_edge, acq_edge, trig_edge;

  always_comb begin
    frm_sync_next = {frm_sync_reg[1:0], i_trig_frame};
    acq_sync_next = {acq_sync_reg[1:0], i_trig_acq};
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      frm_sync_reg <= 3'h0;
      acq_sync_reg <= 3'h0;
    end else begin
      frm_sync_reg <= frm_sync_next;
      acq_sync_reg <= acq_sync_next;
    end
  end

  assign frm_edge  = frm_sync_reg[1] & ~frm_sync_reg[2];
  assign acq_edge  = acq_sync_reg[1] & ~acq_sync_reg[2];
  assign trig_edge = i_legacy_mode ? acq_edge : frm_edge;

  // durations in clock cycles
  logic [`ATG_CNT_W-1:0] exp_raw, exp_len, rd_len;

  always_comb begin
    exp_raw = `ATG_CNT_W'(i_exposure_us) * `ATG_CNT_W'(`ATG_CYC_PER_US);
    exp_len = (exp_raw == '0) ? `ATG_MIN_EXP : exp_raw;
    rd_len  = (`ATG_CNT_W'(i_aoi_height) + `ATG_CNT_W'(1))
              * `ATG_CNT_W'(i_rd_line_cyc)
              + `ATG_CNT_W'(i_rd_fixed_cyc);
  end

  // frame-rate period from the divider
  logic                  div_busy, div_done, div_start;
  logic [`ATG_CNT_W-1:0] div_q;
  logic [`ATG_FPS_W-1:0] fps_reg,   fps_next;
  logic [`ATG_CNT_W-1:0] per_reg,   per_next;
  logic                  per_ok_reg, per_ok_next;
  logic                  lim_on;

  always_comb begin
    fps_next    = fps_reg;
    per_next    = per_reg;
    per_ok_next = per_ok_reg;
    div_start   = 1'b0;
    if (!div_busy && (i_rate_fps != fps_reg)) begin
      fps_next    = i_rate_fps;
      per_ok_next = 1'b0;
      div_start   = (i_rate_fps != '0);
    end else if (div_done) begin
      per_next    = div_q;
      per_ok_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      fps_reg    <= '0;
      per_reg    <= '0;
      per_ok_reg <= 1'b0;
    end else begin
      fps_reg    <= fps_next;
      per_reg    <= per_next;
      per_ok_reg <= per_ok_next;
    end
  end

  atg_rate_div u_div (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_start  (div_start),
    .i_fps    (i_rate_fps),
    .o_busy   (div_busy),
    .o_done   (div_done),
    .o_period (div_q)
  );

  // limit counts only once its period is known; a period shorter than
  // the natural minimum never binds, so the natural rise wins
  assign lim_on = i_rate_lim_en && (fps_reg != '0) && per_ok_reg;

  // acquisition sequencer
  logic [`ATG_CNT_W-1:0] exp_cnt_reg,  exp_cnt_next;
  logic [`ATG_CNT_W-1:0] rd_cnt_reg,   rd_cnt_next;
  logic [`ATG_CNT_W-1:0] rate_cnt_reg, rate_cnt_next;
  logic                  safe_reg,     safe_next;
  logic                  start_reg,    start_next;
  logic                  disc_reg,     disc_next;
  logic                  acc, rd_ok, rate_ok;

  always_comb begin
    acc  = trig_edge && i_hw_trig_en && safe_reg;
    // a discarded trigger touches no counter
    disc_next  = trig_edge && i_hw_trig_en && !safe_reg;
    start_next = acc;
    exp_cnt_next = exp_cnt_reg;
    if (acc) begin
      exp_cnt_next = exp_len;
    end else if (exp_cnt_reg != '0) begin
      exp_cnt_next = exp_cnt_reg - `ATG_CNT_W'(1);
    end
    rd_cnt_next = rd_cnt_reg;
    if (exp_cnt_reg == `ATG_CNT_W'(1)) begin
      rd_cnt_next = rd_len;
    end else if (rd_cnt_reg != '0) begin
      rd_cnt_next = rd_cnt_reg - `ATG_CNT_W'(1);
    end
    rate_cnt_next = rate_cnt_reg;
    if (acc) begin
      rate_cnt_next = `ATG_CNT_W'(1);
    end else if (rate_cnt_reg != `ATG_CNT_MAX) begin
      rate_cnt_next = rate_cnt_reg + `ATG_CNT_W'(1);
    end
    // readout must drain before a new exposure of exp_len could end
    rd_ok   = i_overlap_en ? (rd_cnt_next <= exp_len)
                           : (rd_cnt_next == '0);
    rate_ok = !lim_on || (rate_cnt_next >= per_reg);
    safe_next = i_hw_trig_en && !acc && (exp_cnt_next == '0)
                && rd_ok && rate_ok;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      exp_cnt_reg  <= '0;
      rd_cnt_reg   <= '0;
      rate_cnt_reg <= `ATG_CNT_MAX;
      safe_reg     <= 1'b0;
      start_reg    <= 1'b0;
      disc_reg     <= 1'b0;
    end else begin
      exp_cnt_reg  <= exp_cnt_next;
      rd_cnt_reg   <= rd_cnt_next;
      rate_cnt_reg <= rate_cnt_next;
      safe_reg     <= safe_next;
      start_reg    <= start_next;
      disc_reg     <= disc_next;
    end
  end

  // exposing/reading flags registered from the counters
  logic exp_on_reg, rd_on_reg;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      exp_on_reg <= 1'b0;
      rd_on_reg  <= 1'b0;
    end else begin
      exp_on_reg <= (exp_cnt_next != '0);
      rd_on_reg  <= (rd_cnt_next != '0);
    end
  end

  atg_line_router u_router (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_safe     (safe_reg),
    .i_sel      (i_choose_output_line),
    .i_src_safe (i_source_is_safe_indicator),
    .i_wr       (i_line_src_wr),
    .o_line     (o_line)
  );

  assign o_safe_to_trigger_indicator = safe_reg;
  assign o_acq_start                 = start_reg;
  assign o_trig_discard              = disc_reg;
  assign o_exposing                  = exp_on_reg;
  assign o_reading                   = rd_on_reg;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_no_exp_overlap;
    acc |-> (exp_cnt_reg == '0);
  endproperty
  a_no_exp_overlap: assert property (p_no_exp_overlap)
    else $error("exposure started during exposure");

  property p_rd_before_end;
    (i_overlap_en && exp_cnt_reg == `ATG_CNT_W'(1)) |-> (rd_cnt_reg == '0);
  endproperty
  a_rd_before_end: assert property (p_rd_before_end)
    else $error("exposure ended during readout");

  property p_no_overlap;
    (!i_overlap_en && acc) |-> (rd_cnt_reg == '0);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("exposure started during readout");

  property p_fall_on_start;
    acc |=> (!safe_reg && o_acq_start) ##1 !safe_reg;
  endproperty
  a_fall_on_start: assert property (p_fall_on_start)
    else $error("indicator did not fall on start");

  property p_exp_len;
    acc |=> (exp_cnt_reg == $past(exp_len));
  endproperty
  a_exp_len: assert property (p_exp_len)
    else $error("exposure length not loaded");

  property p_rate;
    (lim_on && $past(lim_on) && rate_cnt_reg < per_reg) |-> !safe_reg;
  endproperty
  a_rate: assert property (p_rate)
    else $error("indicator rose before rate period");

  property p_discard;
    (trig_edge && !safe_reg) |=> !o_acq_start
      && (exp_cnt_reg <= $past(exp_cnt_reg))
      && (rate_cnt_reg >= $past(rate_cnt_reg));
  endproperty
  a_discard: assert property (p_discard)
    else $error("trigger accepted while not ready");

  property p_hw_only;
    !i_hw_trig_en |=> !safe_reg;
  endproperty
  a_hw_only: assert property (p_hw_only)
    else $error("indicator high without hw triggering");

  property p_start_pulse;
    o_acq_start |=> !o_acq_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse longer than one cycle");

  property p_std_pin;
    (!i_legacy_mode && !frm_edge) |-> !acc;
  endproperty
  a_std_pin: assert property (p_std_pin)
    else $error("standard mode accepted a non frame trigger");

  property p_legacy_pin;
    (i_legacy_mode && !acq_edge) |-> !acc;
  endproperty
  a_legacy_pin: assert property (p_legacy_pin)
    else $error("legacy mode accepted a non acquisition trigger");

  property p_exp_ready;
    o_exposing |-> !o_safe_to_trigger_indicator;
  endproperty
  a_exp_ready: assert property (p_exp_ready)
    else $error("indicator high during exposure");

  property p_nonov_ready;
    (!i_overlap_en && !$past(i_overlap_en) && o_reading)
      |-> !o_safe_to_trigger_indicator;
  endproperty
  a_nonov_ready: assert property (p_nonov_ready)
    else $error("indicator high during readout without overlap");

  property p_disc_flag;
    (trig_edge && i_hw_trig_en && !safe_reg) |=> o_trig_discard;
  endproperty
  a_disc_flag: assert property (p_disc_flag)
    else $error("ignored trigger not flagged");

  property p_hw_quiet;
    !i_hw_trig_en |=> !o_acq_start && !o_trig_discard;
  endproperty
  a_hw_quiet: assert property (p_hw_quiet)
    else $error("trigger acted on without hw triggering");

endmodule

// *** dv/atg_trig_src.sv ***
`timescale 1ns/1ps

// trigger source: fires when it sees the indicator, or on command
module atg_trig_src (
  input  wire logic i_clk,      // acquisition clock
  input  wire logic i_ready,    // indicator seen
  input  wire logic i_auto,     // trigger as soon as ready
  input  wire logic i_fire,     // forced trigger
  input  wire logic i_use_acq,  // 1: acq start pin
  output logic      o_frame,    // frame start pin
  output logic      o_acq       // acq start pin
);
  logic [2:0] hold_reg = 3'h0;
  always @(posedge i_clk) begin
    if ((i_auto && i_ready && hold_reg == 3'h0) || i_fire)
      hold_reg <= 3'h4;
    else if (hold_reg != 3'h0)
      hold_reg <= hold_reg - 3'h1;
  end
  assign o_frame = (hold_reg != 3'h0) && !i_use_acq;
  assign o_acq   = (hold_reg != 3'h0) && i_use_acq;
endmodule

// *** dv/atg_gate_tb.sv ***
`timescale 1ns/1ps
`include "atg_defines.svh"

module atg_gate_tb;
  logic i_clk = 1'b0, i_resetn, i_legacy_mode, i_hw_trig_en;
  logic i_overlap_en, i_rate_lim_en, i_source_is_safe_indicator;
  logic i_line_src_wr, i_trig_frame, i_trig_acq, auto, fire, use_acq;
  logic [`ATG_EXP_W-1:0]     i_exposure_us;
  logic [`ATG_AOI_W-1:0]     i_aoi_height;
  logic [`ATG_RDC_W-1:0]     i_rd_line_cyc, i_rd_fixed_cyc;
  logic [`ATG_FPS_W-1:0]     i_rate_fps;
  logic [`ATG_LINE_W-1:0]    i_choose_output_line;
  logic o_safe_to_trigger_indicator, o_acq_start, o_trig_discard;
  logic o_exposing, o_reading, prev_exp = 1'b0, prev_rd = 1'b0, a;
  logic [`ATG_NUM_LINES-1:0] o_line;
  int n_mismatch = 0, cmp_count = 0, seed, rd_left = 0, x, r;

  always #20 i_clk = ~i_clk;

  atg_gate atg_gate_inst (.i_clk, .i_resetn, .i_trig_frame, .i_trig_acq,
    .i_legacy_mode, .i_hw_trig_en, .i_overlap_en, .i_exposure_us,
    .i_aoi_height, .i_rd_line_cyc, .i_rd_fixed_cyc, .i_rate_lim_en,
    .i_rate_fps, .i_choose_output_line, .i_source_is_safe_indicator,
    .i_line_src_wr, .o_safe_to_trigger_indicator, .o_acq_start,
    .o_trig_discard, .o_exposing, .o_reading, .o_line);

  atg_trig_src atg_trig_src_inst (.i_clk,
    .i_ready(o_safe_to_trigger_indicator), .i_auto(auto), .i_fire(fire),
    .i_use_acq(use_acq), .o_frame(i_trig_frame), .o_acq(i_trig_acq));

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // previous-cycle state at each accepted trigger
  always @(negedge i_clk) begin
    if (o_acq_start === 1'b1) begin
      chk("exp_busy", prev_exp, 1'b0);
      if (i_overlap_en) chk("rd_left", rd_left <= x + 2, 1'b1);
      else chk("rd_busy", prev_rd, 1'b0);
    end
    if (prev_exp && o_exposing === 1'b0) rd_left = r;
    else if (rd_left > 0) rd_left--;
    prev_exp = o_exposing;
    prev_rd = o_reading;
  end

  function automatic int exp_rise(int p);
    int n;
    n = i_overlap_en ? (x > r ? x : r) : x + r;
    return (p > n) ? p : n;
  endfunction

  task automatic set(int e, int h, int lc, int fx);
    i_exposure_us = e[`ATG_EXP_W-1:0];
    i_aoi_height = h[`ATG_AOI_W-1:0];
    i_rd_line_cyc = lc[`ATG_RDC_W-1:0];
    i_rd_fixed_cyc = fx[`ATG_RDC_W-1:0];
    x = e * 25;
    r = (h + 1) * lc + fx;
  endtask

  task automatic quiet(int n, output logic acc);
    acc = 1'b0;
    repeat (n) begin
      @(negedge i_clk);
      acc = acc | o_acq_start | o_trig_discard;
    end
  endtask

  task automatic pulse(logic pin);
    use_acq = pin;
    fire = 1'b1;
    @(negedge i_clk);
    fire = 1'b0;
  endtask

  // one triggered frame, optionally with an early retrigger
  task automatic frame(int f, bit dis);
    int n, d, q;
    n = 0;
    d = 0;
    q = 0;
    while (o_acq_start !== 1'b1 && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    chk("acq_seen", o_acq_start, 1'b1);
    chk("rdy_fell", o_safe_to_trigger_indicator, 1'b0);
    n = 0;
    while (o_safe_to_trigger_indicator !== 1'b1 && n < 4000) begin
      fire = dis && n == 4;
      @(negedge i_clk);
      n++;
      d += o_trig_discard;
      q += o_acq_start;
    end
    chk("discards", d, dis);
    chk("no_acq", q, 0);
    if (f > 0) chk("rise", n >= f - 1 && n <= f + 3, 1'b1);
  endtask

  initial begin
    seed = 32'h503e;
    {i_resetn, i_legacy_mode, i_overlap_en, i_rate_lim_en} = 4'h0;
    {i_source_is_safe_indicator, i_line_src_wr, auto, fire} = 4'h0;
    {i_hw_trig_en, use_acq, i_choose_output_line, i_rate_fps} = '0;
    i_hw_trig_en = 1'b1;
    set(1, 0, 1, 0);
    repeat (16) @(negedge i_clk);
    chk("rst_out", {o_line, o_safe_to_trigger_indicator}, 0);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("rdy_up", o_safe_to_trigger_indicator, 1'b1);
    chk("line2", o_line, 4'b0010);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      i_overlap_en = m[0];
      i_legacy_mode = m[1];
      set(1 + {$random(seed)} % 4, {$random(seed)} % 8,
          1 + {$random(seed)} % 8, {$random(seed)} % 16);
      repeat (4) @(negedge i_clk);
      pulse(!m[1]);
      quiet(8, a);
      chk("wrong_pin", a, 1'b0);
      use_acq = m[1];
      auto = 1'b1;
      for (int k = 0; k < 4; k++) frame(exp_rise(0), k[0]);
      auto = 1'b0;
      repeat (300) @(negedge i_clk);
      $display("test mode %0d done", m);
    end
    i_hw_trig_en = 1'b0;
    repeat (4) @(negedge i_clk);
    chk("rdy_off", o_safe_to_trigger_indicator, 1'b0);
    pulse(i_legacy_mode);
    quiet(8, a);
    chk("hw_off_ign", a, 1'b0);
    i_hw_trig_en = 1'b1;
    $display("test hw disable done");
    i_choose_output_line = 2'h0;
    i_source_is_safe_indicator = 1'b1;
    i_line_src_wr = 1'b1;
    @(negedge i_clk);
    i_choose_output_line = 2'h1;
    i_source_is_safe_indicator = 1'b0;
    @(negedge i_clk);
    i_line_src_wr = 1'b0;
    repeat (4) @(negedge i_clk);
    chk("reroute", o_line, 4'b0001);
    $display("test routing done");
    i_overlap_en = 1'b1;
    i_legacy_mode = 1'b0;
    use_acq = 1'b0;
    i_rate_lim_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      i_rate_fps = k ? 16'hEA60 : 16'hC350;
      set(k ? 20 : 1, 0, 1, 0);
      repeat (600) @(negedge i_clk);
      auto = 1'b1;
      frame(0, 0);
      frame(exp_rise(`ATG_CLK_HZ / i_rate_fps), 0);
      auto = 1'b0;
      $display("test rate limit %0d done", k);
    end
    repeat (600) @(negedge i_clk);
    test_done();
  end

  initial begin
    repeat (60000) @(negedge i_clk);
    n_mismatch++;
    $display("Error watchdog expected finish seen timeout");
    test_done();
  end
endmodule
